// ===== fims_pkg.sv
// shared constants and types for the flash interface mode switch sequencer
package fims_pkg;

  // ==================================================
  // commands and feature protocol
  localparam logic [7:0] CMD_SET_FEATURE = 8'hef;
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam int FEATURE_PARAMS = 4;
  localparam logic [2:0] PARAM_LAST = 3'h4;

  // interface select field inside the first parameter byte
  localparam int IF_SEL_BIT = 4;
  localparam int MODE_MSB = 3;
  localparam logic [3:0] MODE_ZERO = 4'h0;

  // ==================================================
  // timing, clock period in ns
  localparam int CLK_NS = 50;
  localparam int MODE_CHANGE_WAIT_NS = 1000;
  localparam int FEATURE_BUSY_NS = 1000;
  localparam int PAGE_READ_INIT_US = 200;
  localparam int INTERLEAVE_BUSY_NS = 500;
  localparam int CACHE_BUSY_NS = 3000;
  localparam int RESET_IDLE_NS = 5000;
  localparam int RESET_PROG_NS = 10000;
  localparam int RESET_ERASE_NS = 50000;
  localparam int PAGE_PROGRAM_NS = 20000;
  localparam int BLOCK_ERASE_NS = 40000;
  localparam int CNT_W = 16;

  // cycle counts: longest-time figures round down; only the mode change wait is held at one or more
  localparam int MODE_CHANGE_CYC = (MODE_CHANGE_WAIT_NS / CLK_NS > 0) ?
                                   MODE_CHANGE_WAIT_NS / CLK_NS : 1;
  localparam int PAGE_READ_INIT_CYC = PAGE_READ_INIT_US * 1000 / CLK_NS;
  localparam int INTERLEAVE_CYC = INTERLEAVE_BUSY_NS / CLK_NS;
  localparam int CACHE_CYC = CACHE_BUSY_NS / CLK_NS;
  localparam int RESET_IDLE_CYC = RESET_IDLE_NS / CLK_NS;
  localparam int RESET_PROG_CYC = RESET_PROG_NS / CLK_NS;
  localparam int RESET_ERASE_CYC = RESET_ERASE_NS / CLK_NS;
  localparam int PAGE_PROGRAM_CYC = PAGE_PROGRAM_NS / CLK_NS;
  localparam int BLOCK_ERASE_CYC = BLOCK_ERASE_NS / CLK_NS;

  // ==================================================
  // array operation requests
  typedef enum logic [2:0] {
    FIMS_OP_PAGE_READ = 3'h0,
    FIMS_OP_PROGRAM = 3'h1,
    FIMS_OP_ERASE = 3'h2,
    FIMS_OP_IL_ERASE = 3'h3,
    FIMS_OP_IL_PROGRAM = 3'h4,
    FIMS_OP_IL_READ = 3'h5,
    FIMS_OP_CACHE_PROGRAM = 3'h6,
    FIMS_OP_CACHE_READ = 3'h7
  } fims_op_t;

  // link pins as seen by the device, after sampling
  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic write_strobe_n;
    logic read_strobe_n;
    logic dqs;
    logic [7:0] dq;
  } fims_link_t;

  // active interface and timing mode
  typedef struct packed {
    logic src_sync;
    logic [3:0] mode;
  } fims_ifmode_t;

  // sequencer states, gray along command, params, wait, back to idle
  typedef enum logic [2:0] {
    FIMS_IDLE = 3'b000,
    FIMS_FADDR = 3'b001,
    FIMS_PARAM = 3'b011,
    FIMS_WAIT = 3'b010,
    FIMS_ARRAY = 3'b110,
    FIMS_RESET = 3'b111
  } fims_state_t;

endpackage

// ===== fims_sync.sv
// three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module fims_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic d_in,
  output logic q_out
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  // ==================================================
  // first stage feeds only the second; change taken once stages 2 and 3 agree
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
      q_out <= RST_VAL;
    end
    else
    begin
      s1_ff <= d_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff)
      begin
        q_out <= s3_ff;
      end
    end
  end
endmodule // fims_sync
`default_nettype wire

// ===== fims_seq.sv
// device-side interface mode switch and array busy sequencer
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - feature command, address and four params are taken in the current mode.
// - device recognises reset FFh in async mode 0 from any mode.
// - reset time has idle, program and erase maxima; program and erase maxima are used only for plain page program and block erase.
// - status ready bit goes low one cycle into the array busy interval and stays low to its end.
// - interleave busy typically 500 ns, bounded by the full operation time; the code uses a fixed 500 ns count, not limited by that time.
// - cache busy typically 3 us, bounded by page program or read time; the code uses a fixed 3 us count, not limited by either time.
// - device starts in async timing mode 0 at power on.
// - mode change wait and feature busy span the ready bit low time; the code times it by the mode change wait alone.
module fims_seq (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire fims_pkg::fims_link_t link_in,
  input wire logic op_req_in,
  input wire fims_pkg::fims_op_t op_in,
  input wire logic init_done_in,
  input wire logic [fims_pkg::CNT_W-1:0] page_read_cyc_in,
  output fims_pkg::fims_ifmode_t ifmode_out,
  output logic status_ready_bit_out,
  output logic ready_busy_n_out,
  output logic op_busy_out
);
  fims_pkg::fims_link_t lk;
  fims_pkg::fims_state_t state_ff;
  fims_pkg::fims_ifmode_t ifmode_ff;
  fims_pkg::fims_ifmode_t pend_ff;
  logic [2:0] pcnt_ff;
  logic [fims_pkg::CNT_W-1:0] cnt_ff;
  logic we_d_ff;
  logic clk_d_ff;
  logic prog_ff;
  logic erase_ff;
  logic first_pp_ff;
  logic we_rise;
  logic clk_rise;
  logic latch_edge;
  logic cmd_cyc;
  logic data_cyc;
  logic async_reset;
  logic [fims_pkg::CNT_W-1:0] op_cyc;
  logic [fims_pkg::CNT_W-1:0] rst_cyc;

  // ==================================================
  // pin synchronisers, one per control pin; data bus sampled through one per bit
  fims_sync #(.RST_VAL(1'b1)) u_ce (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .d_in(link_in.ce_n), .q_out(lk.ce_n));
  fims_sync #(.RST_VAL(1'b0)) u_cle (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .d_in(link_in.cle), .q_out(lk.cle));
  fims_sync #(.RST_VAL(1'b0)) u_ale (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .d_in(link_in.ale), .q_out(lk.ale));
  fims_sync #(.RST_VAL(1'b1)) u_we (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .d_in(link_in.write_strobe_n), .q_out(lk.write_strobe_n));
  fims_sync #(.RST_VAL(1'b1)) u_re (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .d_in(link_in.read_strobe_n), .q_out(lk.read_strobe_n));
  fims_sync #(.RST_VAL(1'b1)) u_dqs (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .d_in(link_in.dqs), .q_out(lk.dqs));
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_dq
      fims_sync #(.RST_VAL(1'b0)) u_dq (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .d_in(link_in.dq[gi]), .q_out(lk.dq[gi]));
    end
  endgenerate

  // ==================================================
  // edge detect on filtered strobes; clock line is the write strobe pin
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      we_d_ff <= 1'b1;
      clk_d_ff <= 1'b1;
    end
    else
    begin
      we_d_ff <= lk.write_strobe_n;
      clk_d_ff <= lk.write_strobe_n;
    end
  end

  assign we_rise = lk.write_strobe_n & ~we_d_ff;
  assign clk_rise = lk.write_strobe_n & ~clk_d_ff;
  // async latches on write strobe rise, sync on clock rise
  assign latch_edge = ifmode_ff.src_sync ? clk_rise : we_rise;
  assign cmd_cyc = latch_edge & ~lk.ce_n & lk.cle & ~lk.ale;
  // sync data input cycle uses both latches high; repeated bytes take one copy
  assign data_cyc = latch_edge & ~lk.ce_n &
                    (ifmode_ff.src_sync ? (lk.cle & lk.ale & lk.read_strobe_n)
                                        : (~lk.cle & ~lk.ale));
  // reset in async mode 0 framing is heard in any state and any mode
  assign async_reset = we_rise & ~lk.ce_n & lk.cle & ~lk.ale & lk.read_strobe_n &
                       (lk.dq == fims_pkg::CMD_RESET);

  // ==================================================
  // busy length per operation; interleave and cache busy are fixed counts, not limited by the full operation time
  always_comb
  begin
    case (op_in)
      fims_pkg::FIMS_OP_PAGE_READ: op_cyc = first_pp_ff ?
        fims_pkg::CNT_W'(fims_pkg::PAGE_READ_INIT_CYC) : page_read_cyc_in;
      fims_pkg::FIMS_OP_PROGRAM: op_cyc = fims_pkg::CNT_W'(fims_pkg::PAGE_PROGRAM_CYC);
      fims_pkg::FIMS_OP_ERASE: op_cyc = fims_pkg::CNT_W'(fims_pkg::BLOCK_ERASE_CYC);
      fims_pkg::FIMS_OP_IL_ERASE,
      fims_pkg::FIMS_OP_IL_PROGRAM,
      fims_pkg::FIMS_OP_IL_READ: op_cyc = fims_pkg::CNT_W'(fims_pkg::INTERLEAVE_CYC);
      fims_pkg::FIMS_OP_CACHE_PROGRAM,
      fims_pkg::FIMS_OP_CACHE_READ: op_cyc = fims_pkg::CNT_W'(fims_pkg::CACHE_CYC);
      default: op_cyc = fims_pkg::CNT_W'(fims_pkg::PAGE_PROGRAM_CYC);
    endcase
  end

  // reset time chosen by what was running when reset arrived
  always_comb
  begin
    if (erase_ff)
      rst_cyc = fims_pkg::CNT_W'(fims_pkg::RESET_ERASE_CYC);
    else if (prog_ff)
      rst_cyc = fims_pkg::CNT_W'(fims_pkg::RESET_PROG_CYC);
    else
      rst_cyc = fims_pkg::CNT_W'(fims_pkg::RESET_IDLE_CYC);
  end

  // ==================================================
  // main sequencer; reset command overrides anything in flight
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_ff <= fims_pkg::FIMS_IDLE;
      pcnt_ff <= 3'h0;
      cnt_ff <= '0;
      pend_ff <= '0;
      prog_ff <= 1'b0;
      erase_ff <= 1'b0;
    end
    else if (async_reset)
    begin
      state_ff <= fims_pkg::FIMS_RESET;
      cnt_ff <= rst_cyc;
      pend_ff <= '0; // back to async mode 0
      pcnt_ff <= 3'h0;
      prog_ff <= 1'b0;
      erase_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        fims_pkg::FIMS_IDLE:
        begin
          if (cmd_cyc && lk.dq == fims_pkg::CMD_SET_FEATURE)
            state_ff <= fims_pkg::FIMS_FADDR;
          else if (op_req_in)
          begin
            state_ff <= fims_pkg::FIMS_ARRAY;
            cnt_ff <= op_cyc;
            prog_ff <= (op_in == fims_pkg::FIMS_OP_PROGRAM);
            erase_ff <= (op_in == fims_pkg::FIMS_OP_ERASE);
          end
        end
        fims_pkg::FIMS_FADDR:
        begin
          if (latch_edge && !lk.ce_n && lk.ale && !lk.cle)
          begin
            state_ff <= fims_pkg::FIMS_PARAM;
            pcnt_ff <= 3'h0;
          end
        end
        fims_pkg::FIMS_PARAM:
        begin
          if (data_cyc)
          begin
            if (pcnt_ff == 3'h0)
            begin
              pend_ff.src_sync <= lk.dq[fims_pkg::IF_SEL_BIT];
              pend_ff.mode <= lk.dq[fims_pkg::MODE_MSB:0];
            end
            pcnt_ff <= pcnt_ff + 3'h1;
            if (pcnt_ff + 3'h1 == fims_pkg::PARAM_LAST)
            begin
              state_ff <= fims_pkg::FIMS_WAIT;
              cnt_ff <= fims_pkg::CNT_W'(fims_pkg::MODE_CHANGE_CYC);
            end
          end
        end
        fims_pkg::FIMS_WAIT, fims_pkg::FIMS_ARRAY, fims_pkg::FIMS_RESET:
        begin
          if (cnt_ff > fims_pkg::CNT_W'(1))
            cnt_ff <= cnt_ff - fims_pkg::CNT_W'(1);
          else
          begin
            state_ff <= fims_pkg::FIMS_IDLE;
            cnt_ff <= '0;
            prog_ff <= 1'b0;
            erase_ff <= 1'b0;
          end
        end
        default: state_ff <= fims_pkg::FIMS_IDLE;
      endcase
    end
  end

  // ==================================================
  // mode applied once the wait ends and chip enable goes high;
  // the host picks the new clock rate only then
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      ifmode_ff <= '0;
    else if (state_ff == fims_pkg::FIMS_IDLE && lk.ce_n)
      ifmode_ff <= pend_ff;
  end

  // first page read uses the conservative time until init completes
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      first_pp_ff <= 1'b1;
    else if (init_done_in)
      first_pp_ff <= 1'b0;
  end

  // ==================================================
  // ready bit low from the second cycle of each busy interval; a reset command drops it at once
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      status_ready_bit_out <= 1'b1;
    else if (async_reset)
      status_ready_bit_out <= 1'b0;
    else
      status_ready_bit_out <= !(state_ff == fims_pkg::FIMS_WAIT ||
        state_ff == fims_pkg::FIMS_ARRAY || state_ff == fims_pkg::FIMS_RESET) ||
        (cnt_ff <= fims_pkg::CNT_W'(1));
  end

  assign ifmode_out = ifmode_ff;
  assign ready_busy_n_out = status_ready_bit_out;
  assign op_busy_out = (state_ff == fims_pkg::FIMS_ARRAY);

  // ==================================================
  // checks
  property p_busy_low;
    @(posedge clk_in) disable iff (!arst_n_in)
      (state_ff == fims_pkg::FIMS_ARRAY && cnt_ff > fims_pkg::CNT_W'(1))
        |=> !status_ready_bit_out;
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("ready bit high while busy");

  property p_reset_heard;
    @(posedge clk_in) disable iff (!arst_n_in)
      async_reset |=> (state_ff == fims_pkg::FIMS_RESET) && (pend_ff == '0);
  endproperty
  a_reset_heard: assert property (p_reset_heard) else $error("reset not taken");

  property p_wait_len;
    @(posedge clk_in) disable iff (!arst_n_in)
      (state_ff == fims_pkg::FIMS_WAIT && cnt_ff > fims_pkg::CNT_W'(1))
        |=> !status_ready_bit_out;
  endproperty
  a_wait_len: assert property (p_wait_len) else $error("ready bit high in mode wait");

  property p_wait_load;
    @(posedge clk_in) disable iff (!arst_n_in)
      (state_ff == fims_pkg::FIMS_WAIT && $past(state_ff) == fims_pkg::FIMS_PARAM
       && !$past(async_reset))
        |-> cnt_ff == fims_pkg::CNT_W'(fims_pkg::MODE_CHANGE_CYC);
  endproperty
  a_wait_load: assert property (p_wait_load) else $error("mode wait not loaded");

  property p_mode_hold;
    @(posedge clk_in) disable iff (!arst_n_in)
      !lk.ce_n |=> ifmode_ff == $past(ifmode_ff);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed with chip enabled");

  property p_rst_len;
    @(posedge clk_in) disable iff (!arst_n_in)
      (async_reset && erase_ff) |=> cnt_ff == fims_pkg::CNT_W'(fims_pkg::RESET_ERASE_CYC);
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("erase reset time wrong");

  property p_first_read;
    @(posedge clk_in) disable iff (!arst_n_in)
      (state_ff == fims_pkg::FIMS_IDLE && op_req_in && !async_reset && !cmd_cyc &&
       op_in == fims_pkg::FIMS_OP_PAGE_READ && first_pp_ff)
        |=> cnt_ff == fims_pkg::CNT_W'(fims_pkg::PAGE_READ_INIT_CYC);
  endproperty
  a_first_read: assert property (p_first_read) else $error("first read time wrong");

  property p_short_busy;
    @(posedge clk_in) disable iff (!arst_n_in)
      (state_ff == fims_pkg::FIMS_IDLE && op_req_in && !async_reset && !cmd_cyc &&
       op_in == fims_pkg::FIMS_OP_IL_READ)
        |=> cnt_ff == fims_pkg::CNT_W'(fims_pkg::INTERLEAVE_CYC);
  endproperty
  a_short_busy: assert property (p_short_busy) else $error("interleave busy wrong");
endmodule // fims_seq
`default_nettype wire

// ===== fims_host.sv
// behavioural host flash controller driving the link pins of the sequencer
`timescale 1ns/1ps
`default_nettype none
module fims_host (
  input wire logic clk_in,
  output var fims_pkg::fims_link_t link_out
);
  // ==================================================
  // idle pins: latches low, strobes and data strobe high
  initial link_out = 14'h2700;

  // all pin changes land on the falling clock edge
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // one bus cycle; reps 2 repeats a data byte in source sync mode
  task automatic send(input logic cle, input logic ale, input logic [7:0] d, input int reps);
    wait_clk(1);
    link_out.cle = cle;
    link_out.ale = ale;
    link_out.dq = d;
    wait_clk(4);
    link_out.write_strobe_n = 1'b0; // 400 ns link clock, still outside frames
    wait_clk(4);
    link_out.write_strobe_n = 1'b1; // rising edge carries the latched copy
    if (reps > 1)
    begin
      wait_clk(4);
      link_out.write_strobe_n = 1'b0; // falling edge carries the repeat copy
    end
    wait_clk(4);
    link_out.cle = 1'b0;
    link_out.ale = 1'b0;
    link_out.dq = ~d; // released bus must not hold the old byte
    if (reps > 1)
    begin
      wait_clk(4);
      link_out.write_strobe_n = 1'b1; // idle rise closes the bus state, clock parks high
    end
  endtask

  // chip enable only moves with both latches low
  task automatic set_ce(input logic ce_n);
    wait_clk(4);
    link_out.ce_n = ce_n;
    wait_clk(8);
  endtask
endmodule // fims_host
`default_nettype wire

// ===== flash_interface_mode_switch_bench.sv
// self-checking testbench for the interface mode switch sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_interface_mode_switch_bench;
  logic clk_in;
  logic arst_n_in;
  logic op_req;
  fims_pkg::fims_op_t op;
  logic init_done;
  logic [15:0] page_cyc;
  fims_pkg::fims_link_t link;
  fims_pkg::fims_ifmode_t ifmode;
  logic ready;
  logic rb;
  logic op_busy;
  int error_cnt = 0;
  int comparisons = 0;
  int run_cnt = 0;
  int last_busy = 0;

  // ==================================================
  // clock, partner and design
  always #25 clk_in = ~clk_in;

  fims_host host (.clk_in(clk_in), .link_out(link));

  fims_seq dut (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .link_in(link), .op_req_in(op_req),
    .op_in(op), .init_done_in(init_done), .page_read_cyc_in(page_cyc),
    .ifmode_out(ifmode), .status_ready_bit_out(ready), .ready_busy_n_out(rb),
    .op_busy_out(op_busy)
  );

  // length of the last low run of the ready bit
  always @(posedge clk_in)
  begin
    if (ready === 1'b0) run_cnt <= run_cnt + 1;
    else
    begin
      if (run_cnt != 0) last_busy <= run_cnt;
      run_cnt <= 0;
    end
  end

  // ==================================================
  // checking helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] in_rng(input int v, input int lo, input int hi);
    return {31'h0, (v >= lo) && (v <= hi)};
  endfunction

  // busy may already have started; bounded waits for fall then rise
  task automatic wait_ready();
    for (int i = 0; i < 20 && ready !== 1'b0; i++) host.wait_clk(1);
    for (int i = 0; i < 6000 && ready !== 1'b1; i++) host.wait_clk(1);
    host.wait_clk(2);
  endtask

  task automatic feature(input logic sync, input logic [7:0] p1);
    host.send(1'b1, 1'b0, fims_pkg::CMD_SET_FEATURE, 1);
    host.send(1'b0, 1'b1, 8'h01, 1);
    for (int i = 0; i < fims_pkg::FEATURE_PARAMS; i++)
      host.send(sync, sync, (i == 0) ? p1 : 8'h00, sync ? 2 : 1);
    wait_ready();
    check(in_rng(last_busy, fims_pkg::MODE_CHANGE_CYC - 2,
      fims_pkg::MODE_CHANGE_CYC + 4), 32'h1);
  endtask

  // new mode shows only once chip enable has been high
  task automatic check_mode(input logic [4:0] old_m, input logic [4:0] new_m);
    check({27'h0, ifmode}, {27'h0, old_m});
    host.set_ce(1'b1);
    check({27'h0, ifmode}, {27'h0, new_m});
    host.set_ce(1'b0);
  endtask

  task automatic start_op(input fims_pkg::fims_op_t o);
    @(negedge clk_in);
    op_req = 1'b1;
    op = o;
    @(negedge clk_in);
    op_req = 1'b0;
    host.wait_clk(2);
    check({31'h0, op_busy}, 32'h1);
  endtask

  function automatic int exp_cyc(input fims_pkg::fims_op_t o);
    case (o)
      fims_pkg::FIMS_OP_PAGE_READ: return init_done ? int'(page_cyc) : fims_pkg::PAGE_READ_INIT_CYC;
      fims_pkg::FIMS_OP_PROGRAM: return fims_pkg::PAGE_PROGRAM_CYC;
      fims_pkg::FIMS_OP_ERASE: return fims_pkg::BLOCK_ERASE_CYC;
      fims_pkg::FIMS_OP_CACHE_PROGRAM, fims_pkg::FIMS_OP_CACHE_READ: return fims_pkg::CACHE_CYC;
      default: return fims_pkg::INTERLEAVE_CYC;
    endcase
  endfunction

  // ==================================================
  // scenarios
  task automatic t_reset_state();
    check({27'h0, ifmode}, 32'h0);
    check({30'h0, ready, rb}, 32'h3);
    check({31'h0, op_busy}, 32'h0);
    // chip enable parks high out of reset; commands need it low
    host.set_ce(1'b0);
    check({27'h0, ifmode}, 32'h0);
    $display("test reset_state done");
  endtask

  task automatic t_mode_changes();
    feature(1'b0, 8'h13); // async mode 0 to sync mode 3
    check_mode(5'h00, 5'h13);
    feature(1'b1, 8'h15); // sync to sync, repeated bytes latched once
    check_mode(5'h13, 5'h15);
    $display("test mode_changes done");
  endtask

  // foreign commands leave the ready bit alone
  task automatic t_refused();
    host.send(1'b1, 1'b0, 8'h90, 1);
    host.wait_clk(8);
    check({31'h0, ready}, 32'h1);
    check({27'h0, ifmode}, 32'h15);
    $display("test refused done");
  endtask

  task automatic t_reset_to_async();
    host.send(1'b1, 1'b0, fims_pkg::CMD_RESET, 1);
    wait_ready();
    check(in_rng(last_busy, fims_pkg::RESET_IDLE_CYC - 2,
      fims_pkg::RESET_IDLE_CYC + 6), 32'h1);
    check_mode(5'h15, 5'h00);
    feature(1'b0, 8'h01);
    check_mode(5'h00, 5'h01);
    $display("test reset_to_async done");
  endtask

  // every operation kind, page read before and after initialisation
  task automatic t_array_ops();
    for (int k = 0; k < 9; k++)
    begin
      // reported time differs from the start value, so a stale count shows
      if (k == 8)
      begin
        init_done = 1'b1;
        page_cyc = 16'h0046;
      end
      start_op(fims_pkg::fims_op_t'(k % 8));
      wait_ready();
      check(in_rng(last_busy, exp_cyc(fims_pkg::fims_op_t'(k % 8)) - 1,
        exp_cyc(fims_pkg::fims_op_t'(k % 8)) + 3), 32'h1);
    end
    $display("test array_ops done");
  endtask

  // reset in mid-program and mid-erase takes the longer limit
  task automatic t_reset_busy();
    start_op(fims_pkg::FIMS_OP_PROGRAM);
    host.send(1'b1, 1'b0, fims_pkg::CMD_RESET, 1);
    wait_ready();
    check(in_rng(last_busy, fims_pkg::RESET_PROG_CYC, fims_pkg::RESET_PROG_CYC + 40), 32'h1);
    start_op(fims_pkg::FIMS_OP_ERASE);
    host.send(1'b1, 1'b0, fims_pkg::CMD_RESET, 1);
    wait_ready();
    check(in_rng(last_busy, fims_pkg::RESET_ERASE_CYC, fims_pkg::RESET_ERASE_CYC + 40), 32'h1);
    $display("test reset_busy done");
  endtask

  // ==================================================
  // verdict and sequence
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // watchdog: tests need well under 1 ms of simulated time
  initial
  begin
    #3000000;
    error_cnt++;
    finish_test();
  end

  initial
  begin
    clk_in = 1'b0;
    arst_n_in = 1'b0;
    op_req = 1'b0;
    op = fims_pkg::FIMS_OP_PAGE_READ;
    init_done = 1'b0;
    page_cyc = 16'h0032;
    repeat (3) @(negedge clk_in);
    arst_n_in = 1'b1;
    host.wait_clk(2);
    t_reset_state();
    t_mode_changes();
    t_refused();
    t_reset_to_async();
    t_array_ops();
    t_reset_busy();
    finish_test();
  end
endmodule // flash_interface_mode_switch_bench
`default_nettype wire
